// ---- rtl/ctms_top.sv ----
// Transmit mailbox status block: register port, mailbox slots, ranking, interrupt
`timescale 1ns/10ps
`default_nettype none
module ctms_top #(
  parameter int KEY_W = 29
) (
  // Clock and reset
  input  wire logic                                            clk_i,
  input  wire logic                                            rst_i,
  // Register port
  input  wire logic [ctms_pkg::ADDR_W-1:0]                     addr_i,
  input  wire logic [ctms_pkg::DATA_W-1:0]                     wdata_i,
  input  wire logic                                            wr_i,
  input  wire logic                                            rd_i,
  output logic      [ctms_pkg::DATA_W-1:0]                     rdata_o,
  // Mailbox priority keys
  input  wire logic [ctms_pkg::NUM_MBOX-1:0][KEY_W-1:0]        key_i,
  // Protocol engine
  input  wire ctms_pkg::ctms_eng_start_t                       eng_start_i,
  input  wire ctms_pkg::ctms_eng_evt_t                         eng_evt_i,
  output logic      [ctms_pkg::NUM_MBOX-1:0]                   eng_pending_o,
  output logic      [ctms_pkg::MBOX_W-1:0]                     eng_next_o,
  output logic      [ctms_pkg::NUM_MBOX-1:0]                   eng_abort_o,
  // Interrupt
  output logic                                                 irq_o
);
  import ctms_pkg::*;

  logic                               wr_status;
  logic                               wr_req;
  logic                               wr_ctrl;
  logic                               wr_mask;
  logic                               rd_irq;
  logic [CTRL_W-1:0]                  ctrl;
  logic [IRQ_W-1:0]                   irq_stat;
  logic [IRQ_W-1:0]                   irq_mask;
  logic [IRQ_W-1:0]                   irq_set;
  logic [NUM_MBOX-1:0]                pending;
  logic [NUM_MBOX-1:0]                abort;
  logic [NUM_MBOX-1:0][FLAG_W-1:0]    flags;
  logic [NUM_MBOX-1:0]                done_evt;
  logic [NUM_MBOX-1:0]                arb_evt;
  logic [NUM_MBOX-1:0]                err_evt;
  logic [NUM_MBOX-1:0]                req;
  logic [NUM_MBOX-1:0]                vacant;
  logic [NUM_MBOX-1:0][NUM_MBOX-1:0]  older;
  logic [NUM_MBOX-1:0]                pend_last;
  logic [MBOX_W-1:0]                  pend_first_num;
  logic [MBOX_W-1:0]                  all_last_num;
  logic [NUM_MBOX-1:0]                send_mask;
  logic [NUM_MBOX-1:0]                least;
  logic [MBOX_W-1:0]                  free_code;
  logic                               multi_pending;
  logic [DATA_W-1:0]                  status_word;
  logic [DATA_W-1:0]                  next_rdata;

  // Address decode
  assign wr_status = wr_i && (addr_i == OFS_STATUS);
  assign wr_req    = wr_i && (addr_i == OFS_TX_REQ);
  assign wr_ctrl   = wr_i && (addr_i == OFS_CTRL);
  assign wr_mask   = wr_i && (addr_i == OFS_IRQ_MASK);
  assign rd_irq    = rd_i && (addr_i == OFS_IRQ_STAT);

  assign vacant = ~pending;

  // Mailbox slots
  for (genvar i = 0; i < NUM_MBOX; i++) begin : g_slot
    logic [FLAG_W-1:0] clr;
    logic              start;
    logic              evt;

    // Only ones in the flag nibble clear; zeros leave flags alone
    assign clr   = wr_status ? wdata_i[i*MBOX_STRIDE +: FLAG_W] : '0; // RULE_14
    assign req[i] = wr_req && wdata_i[i];
    assign start = eng_start_i.valid && (eng_start_i.mbox == MBOX_W'(i));
    assign evt   = eng_evt_i.valid && (eng_evt_i.mbox == MBOX_W'(i));

    ctms_slot u_slot (
      .clk_i      (clk_i),
      .rst_i      (rst_i),
      .req_i      (req[i]),
      .abort_wr_i (wr_status && wdata_i[i*MBOX_STRIDE + BIT_ABORT]), // RULE_01
      .clr_i      (clr),
      .no_retry_i (ctrl[CTRL_NO_RETRY]),
      .start_i    (start),
      .evt_i      (evt),
      .res_i      (eng_evt_i.result),
      .pending_o  (pending[i]),
      .abort_o    (abort[i]),
      .flags_o    (flags[i]),
      .done_evt_o (done_evt[i]),
      .arb_evt_o  (arb_evt[i]),
      .err_evt_o  (err_evt[i])
    );

    // Mailbox 0 lands in bits 3:0 since its lane starts at zero
    assign status_word[i*MBOX_STRIDE +: FLAG_W] = flags[i]; // RULE_13
    assign status_word[i*MBOX_STRIDE + FLAG_W +: BIT_ABORT - FLAG_W] = '0;
    assign status_word[i*MBOX_STRIDE + BIT_ABORT] = abort[i];
    assign status_word[VACANT_LSB + i] = vacant[i]; // RULE_10
    assign status_word[LEAST_LSB + i] = least[i];
  end

  assign status_word[FREE_LSB +: MBOX_W] = free_code;

  // Request order, for order-based priority: older[a][b] means a came first
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      older <= '0;
    end else begin
      for (int a = 0; a < NUM_MBOX; a++) begin
        for (int b = 0; b < NUM_MBOX; b++) begin
          if (a != b) begin
            if (req[a] && vacant[a] && req[b] && vacant[b]) begin
              older[a][b] <= (a < b);
            end else if (req[b] && vacant[b]) begin
              older[a][b] <= 1'b1;
            end else if (req[a] && vacant[a]) begin
              older[a][b] <= 1'b0;
            end
          end
        end
      end
    end
  end

  // Ranking among waiting mailboxes
  ctms_prio #(
    .KEY_W (KEY_W)
  ) u_prio_pend (
    .mask_i       (pending),
    .key_i        (key_i),
    .order_mode_i (ctrl[CTRL_ORDER_PRIO]),
    .older_i      (older),
    .first_o      (),
    .last_o       (pend_last),
    .first_num_o  (pend_first_num),
    .last_num_o   ()
  );

  // Ranking across all mailboxes, used only when none is waiting
  ctms_prio #(
    .KEY_W (KEY_W)
  ) u_prio_all (
    .mask_i       ({NUM_MBOX{1'b1}}),
    .key_i        (key_i),
    .order_mode_i (ctrl[CTRL_ORDER_PRIO]),
    .older_i      (older),
    .first_o      (),
    .last_o       (),
    .first_num_o  (),
    .last_num_o   (all_last_num)
  );

  always_comb begin
    multi_pending = 1'b0;
    for (int k = 0; k < NUM_MBOX; k++) begin
      for (int m = k + 1; m < NUM_MBOX; m++) begin
        if (pending[k] && pending[m]) begin
          multi_pending = 1'b1;
        end
      end
    end
  end

  assign least = multi_pending ? pend_last : '0; // RULE_11 RULE_12

  // With any mailbox waiting the code just tracks the next to send
  always_comb begin
    if (&vacant) begin
      free_code = all_last_num; // RULE_08
    end else begin
      free_code = pend_first_num; // RULE_09
    end
  end

  // Engine view: aborted mailboxes are not offered for a fresh start
  assign send_mask     = pending & ~abort;
  assign eng_pending_o = send_mask;
  assign eng_abort_o   = abort;
  assign eng_next_o    = pend_first_num;

  // Control register
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl <= CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl <= wdata_i[CTRL_W-1:0];
    end
  end

  // Interrupt status: sticky, cleared by reading it, a new event wins
  assign irq_set = {err_evt, arb_evt, done_evt};

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_stat <= IRQ_RST;
    end else if (rd_irq) begin
      irq_stat <= irq_set;
    end else begin
      irq_stat <= irq_stat | irq_set;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_mask <= IRQ_RST;
    end else if (wr_mask) begin
      irq_mask <= wdata_i[IRQ_W-1:0];
    end
  end

  assign irq_o = |(irq_stat & irq_mask);

  // Read mux; unmapped offsets read as zero
  always_comb begin
    next_rdata = DATA_ZERO;
    if (rd_i) begin
      case (addr_i)
        OFS_STATUS: begin
          next_rdata = status_word;
        end
        OFS_CTRL: begin
          next_rdata[CTRL_W-1:0] = ctrl;
        end
        OFS_IRQ_STAT: begin
          next_rdata[IRQ_W-1:0] = irq_stat;
        end
        OFS_IRQ_MASK: begin
          next_rdata[IRQ_W-1:0] = irq_mask;
        end
        OFS_TX_REQ: begin
          next_rdata[NUM_MBOX-1:0] = pending;
        end
        default: begin
          next_rdata = DATA_ZERO;
        end
      endcase
    end
  end

  // Data stands only in the cycle after the read strobe
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= DATA_ZERO;
    end else begin
      rdata_o <= next_rdata;
    end
  end

endmodule // ctms_top
`default_nettype wire

// ---- rtl/ctms_pkg.sv ----
// Constants, types and register layout for the transmit mailbox status block
// How it works
// RULE_01: Software sets abort; hardware clears on removal.
// RULE_02: Abort write ignored while mailbox is vacant.
// RULE_03: Done flag set when request or abort finishes.
// RULE_04: New request clears done; write-one also clears.
// RULE_05: Success flag shows latest attempt; write-one clears.
// RULE_06: Arbitration-lost flag set on loss; write-one clears.
// RULE_07: Error flag set on failed send; write-one clears.
// RULE_08: All vacant: code names lowest priority mailbox.
// RULE_09: Some vacant: code names next mailbox to send.
// RULE_10: Vacant flag high while mailbox holds nothing.
// RULE_11: Least-priority flag marks lowest waiting mailbox.
// RULE_12: Single waiting mailbox clears all least flags.
// RULE_13: Mailbox 0 flags sit in lowest four bits.
// RULE_14: Zero writes and read-only fields change nothing.
package ctms_pkg;

  localparam int NUM_MBOX = 3;
  localparam int MBOX_W   = 2;
  localparam int ADDR_W   = 8;
  localparam int DATA_W   = 32;
  localparam int FLAG_W   = 4;
  localparam int IRQ_W    = 9;

  // Register offsets
  localparam logic [ADDR_W-1:0] OFS_STATUS   = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_TX_REQ   = 8'h40;
  localparam logic [ADDR_W-1:0] OFS_CTRL     = 8'h44;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 8'h48;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h4C;

  // Status word layout, one byte lane per mailbox
  localparam int MBOX_STRIDE = 8;
  localparam int BIT_DONE    = 0;
  localparam int BIT_OK      = 1;
  localparam int BIT_ARB     = 2;
  localparam int BIT_ERR     = 3;
  localparam int BIT_ABORT   = 7;
  localparam int FREE_LSB    = 24;
  localparam int VACANT_LSB  = 26;
  localparam int LEAST_LSB   = 29;

  // Control and interrupt layout
  localparam int CTRL_NO_RETRY   = 0;
  localparam int CTRL_ORDER_PRIO = 1;
  localparam int CTRL_W          = 2;
  localparam int IRQ_DONE_LSB    = 0;
  localparam int IRQ_ARB_LSB     = 3;
  localparam int IRQ_ERR_LSB     = 6;

  // Reset values
  localparam logic [FLAG_W-1:0]   FLAGS_RST = 4'h0;
  localparam logic [CTRL_W-1:0]   CTRL_RST  = 2'h0;
  localparam logic [IRQ_W-1:0]    IRQ_RST   = 9'h000;
  localparam logic [DATA_W-1:0]   DATA_ZERO = 32'h0000_0000;

  typedef enum logic [1:0] {
    CTMS_RES_OK  = 2'h0,
    CTMS_RES_ARB = 2'h1,
    CTMS_RES_ERR = 2'h3
  } ctms_result_t;

  typedef enum logic [1:0] {
    CTMS_MB_IDLE   = 2'h0,
    CTMS_MB_PEND   = 2'h1,
    CTMS_MB_ACTIVE = 2'h3
  } ctms_mb_state_t;

  // Outcome of one transmit attempt reported by the protocol engine
  typedef struct packed {
    logic              valid;
    logic [MBOX_W-1:0] mbox;
    ctms_result_t      result;
  } ctms_eng_evt_t;

  // Engine picking up a mailbox for the bus
  typedef struct packed {
    logic              valid;
    logic [MBOX_W-1:0] mbox;
  } ctms_eng_start_t;

endpackage

// ---- rtl/ctms_prio.sv ----
// Priority ranking of a set of mailboxes: first to send and last to send
`timescale 1ns/10ps
`default_nettype none
module ctms_prio #(
  parameter int KEY_W = 29
) (
  // Candidates and their keys
  input  wire logic [ctms_pkg::NUM_MBOX-1:0]                  mask_i,
  input  wire logic [ctms_pkg::NUM_MBOX-1:0][KEY_W-1:0]       key_i,
  input  wire logic                                           order_mode_i,
  input  wire logic [ctms_pkg::NUM_MBOX-1:0][ctms_pkg::NUM_MBOX-1:0] older_i,
  // Ranking
  output logic      [ctms_pkg::NUM_MBOX-1:0]                  first_o,
  output logic      [ctms_pkg::NUM_MBOX-1:0]                  last_o,
  output logic      [ctms_pkg::MBOX_W-1:0]                    first_num_o,
  output logic      [ctms_pkg::MBOX_W-1:0]                    last_num_o
);
  import ctms_pkg::*;

  logic [NUM_MBOX-1:0][NUM_MBOX-1:0] ahead;
  logic [NUM_MBOX-1:0][NUM_MBOX-1:0] beats;
  logic [NUM_MBOX-1:0][NUM_MBOX-1:0] loses;

  // Lower key wins; equal keys go to the lower mailbox number
  for (genvar i = 0; i < NUM_MBOX; i++) begin : g_row
    for (genvar j = 0; j < NUM_MBOX; j++) begin : g_col
      if (i == j) begin : g_self
        assign ahead[i][j] = 1'b0;
        assign beats[i][j] = 1'b1;
        assign loses[i][j] = 1'b1;
      end else begin : g_pair
        if (i < j) begin : g_low
          assign ahead[i][j] = order_mode_i ? older_i[i][j] : (key_i[i] <= key_i[j]);
        end else begin : g_high
          assign ahead[i][j] = order_mode_i ? older_i[i][j] : (key_i[i] < key_i[j]);
        end
        assign beats[i][j] = ahead[i][j] | ~mask_i[j];
        assign loses[i][j] = ahead[j][i] | ~mask_i[j];
      end
    end
    assign first_o[i] = mask_i[i] & (&beats[i]);
    assign last_o[i]  = mask_i[i] & (&loses[i]);
  end

  always_comb begin
    first_num_o = '0;
    last_num_o  = '0;
    for (int k = 0; k < NUM_MBOX; k++) begin
      if (first_o[k]) begin
        first_num_o = MBOX_W'(k);
      end
      if (last_o[k]) begin
        last_num_o = MBOX_W'(k);
      end
    end
  end

endmodule // ctms_prio
`default_nettype wire

// ---- rtl/ctms_slot.sv ----
// One transmit mailbox: occupancy state, abort bit and its four status flags
`timescale 1ns/10ps
`default_nettype none
module ctms_slot (
  // Clock and reset
  input  wire logic                          clk_i,
  input  wire logic                          rst_i,
  // Software side
  input  wire logic                          req_i,
  input  wire logic                          abort_wr_i,
  input  wire logic [ctms_pkg::FLAG_W-1:0]   clr_i,
  input  wire logic                          no_retry_i,
  // Engine side
  input  wire logic                          start_i,
  input  wire logic                          evt_i,
  input  wire ctms_pkg::ctms_result_t        res_i,
  // State and flags
  output logic                               pending_o,
  output logic                               abort_o,
  output logic      [ctms_pkg::FLAG_W-1:0]   flags_o,
  output logic                               done_evt_o,
  output logic                               arb_evt_o,
  output logic                               err_evt_o
);
  import ctms_pkg::*;

  ctms_mb_state_t state;
  ctms_mb_state_t next_state;
  logic           complete;
  logic           good;
  logic           failed;
  logic           accept;

  assign accept    = req_i && (state == CTMS_MB_IDLE);
  assign arb_evt_o = evt_i && (state == CTMS_MB_ACTIVE) && (res_i == CTMS_RES_ARB);
  assign err_evt_o = evt_i && (state == CTMS_MB_ACTIVE) && (res_i == CTMS_RES_ERR);
  assign failed    = arb_evt_o || err_evt_o || ((state == CTMS_MB_PEND) && abort_o);
  assign done_evt_o = complete;
  assign pending_o = (state != CTMS_MB_IDLE);

  // A frame already on the bus cannot be pulled; abort waits for its outcome
  always_comb begin
    next_state = state;
    complete   = 1'b0;
    good       = 1'b0;
    case (state)
      CTMS_MB_IDLE: begin
        if (req_i) begin
          next_state = CTMS_MB_PEND;
        end
      end
      CTMS_MB_PEND: begin
        if (abort_o) begin
          next_state = CTMS_MB_IDLE; // RULE_01
          complete   = 1'b1;
        end else if (start_i) begin
          next_state = CTMS_MB_ACTIVE;
        end
      end
      CTMS_MB_ACTIVE: begin
        if (evt_i) begin
          if (res_i == CTMS_RES_OK) begin
            next_state = CTMS_MB_IDLE;
            complete   = 1'b1;
            good       = 1'b1;
          end else if (no_retry_i || abort_o) begin
            next_state = CTMS_MB_IDLE;
            complete   = 1'b1;
          end else begin
            next_state = CTMS_MB_PEND;
          end
        end
      end
      default: begin
        next_state = CTMS_MB_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state <= CTMS_MB_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      abort_o <= 1'b0;
    end else if (next_state == CTMS_MB_IDLE) begin
      abort_o <= 1'b0; // RULE_01
    end else if (abort_wr_i && pending_o) begin
      abort_o <= 1'b1; // RULE_02
    end
  end

  // Hardware set wins over a write-one clear in the same cycle
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      flags_o <= FLAGS_RST;
    end else begin
      if (complete) begin
        flags_o[BIT_DONE] <= 1'b1; // RULE_03
      end else if (accept || clr_i[BIT_DONE]) begin
        flags_o[BIT_DONE] <= 1'b0; // RULE_04
      end
      if (good) begin
        flags_o[BIT_OK] <= 1'b1; // RULE_05
      end else if (failed || clr_i[BIT_OK]) begin
        flags_o[BIT_OK] <= 1'b0; // RULE_05
      end
      if (arb_evt_o) begin
        flags_o[BIT_ARB] <= 1'b1; // RULE_06
      end else if (clr_i[BIT_ARB]) begin
        flags_o[BIT_ARB] <= 1'b0; // RULE_06
      end
      if (err_evt_o) begin
        flags_o[BIT_ERR] <= 1'b1; // RULE_07
      end else if (clr_i[BIT_ERR]) begin
        flags_o[BIT_ERR] <= 1'b0; // RULE_07
      end
    end
  end

endmodule // ctms_slot
`default_nettype wire

// ---- verification/ctms_monitor.sv ----
// Port-level assertions for the transmit mailbox status block
`timescale 1ns/10ps
`default_nettype none
module ctms_monitor (
  // Clock and reset
  input wire logic                          clk_i,
  input wire logic                          rst_i,
  // Register port
  input wire logic [ctms_pkg::ADDR_W-1:0]   addr_i,
  input wire logic [ctms_pkg::DATA_W-1:0]   wdata_i,
  input wire logic                          wr_i,
  input wire logic                          rd_i,
  // Engine and interrupt
  input wire ctms_pkg::ctms_eng_start_t     eng_start_i,
  input wire ctms_pkg::ctms_eng_evt_t       eng_evt_i,
  input wire logic [ctms_pkg::NUM_MBOX-1:0] eng_pending_o,
  input wire logic [ctms_pkg::MBOX_W-1:0]   eng_next_o,
  input wire logic [ctms_pkg::NUM_MBOX-1:0] eng_abort_o,
  input wire logic                          irq_o
);
  import ctms_pkg::*;
  logic [NUM_MBOX-1:0] act;
  logic                idle1;
  // Sending state is only visible through the start and outcome pulses
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      act <= '0;
    end else begin
      for (int n = 0; n < NUM_MBOX; n++) begin
        if (eng_evt_i.valid && eng_evt_i.mbox == MBOX_W'(n)) begin
          act[n] <= 1'b0;
        end else if (eng_start_i.valid && eng_start_i.mbox == MBOX_W'(n) && eng_pending_o[n]) begin
          act[n] <= 1'b1;
        end
      end
    end
  end
  assign idle1 = !eng_pending_o[1] && !eng_abort_o[1] && !act[1];
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  sequence s_abort_wr1;
    wr_i && addr_i == OFS_STATUS && wdata_i[MBOX_STRIDE + BIT_ABORT];
  endsequence
  sequence s_abort_up1;
    $rose(eng_abort_o[1]) && !act[1];
  endsequence
  property p_abort_ignored;
    s_abort_wr1 ##0 idle1 |=> !eng_abort_o[1];
  endproperty
  a_abort_ignored: assert property (p_abort_ignored)
    else $error("abort taken on vacant mailbox");
  property p_abort_set;
    s_abort_wr1 ##0 (eng_pending_o[1] && !eng_start_i.valid) |=> eng_abort_o[1];
  endproperty
  a_abort_set: assert property (p_abort_set)
    else $error("abort not taken");
  property p_abort_release;
    s_abort_up1 |=> !eng_abort_o[1];
  endproperty
  a_abort_release: assert property (p_abort_release)
    else $error("abort of queued mailbox not released");
  property p_abort_hold;
    eng_abort_o[1] && act[1] && !(eng_evt_i.valid && eng_evt_i.mbox == 2'h1) |=> eng_abort_o[1];
  endproperty
  a_abort_hold: assert property (p_abort_hold)
    else $error("abort dropped before outcome");
  property p_irq_clear;
    rd_i && addr_i == OFS_IRQ_STAT && !eng_evt_i.valid && !(|eng_abort_o) |=> !irq_o;
  endproperty
  a_irq_clear: assert property (p_irq_clear)
    else $error("interrupt stays after status read");
  property p_pending_req;
    wr_i && addr_i == OFS_TX_REQ && wdata_i[1] && idle1 |=> eng_pending_o[1];
  endproperty
  a_pending_req: assert property (p_pending_req)
    else $error("request not queued");
  property p_evt_ok_release;
    eng_evt_i.valid && eng_evt_i.mbox == 2'h0 && eng_evt_i.result == CTMS_RES_OK && act[0]
      |=> !eng_pending_o[0];
  endproperty
  a_evt_ok_release: assert property (p_evt_ok_release)
    else $error("mailbox still queued after success");
  property p_next_single;
    eng_pending_o == 3'h2 && act == 3'h0 && eng_abort_o == 3'h0 |-> eng_next_o == 2'h1;
  endproperty
  a_next_single: assert property (p_next_single)
    else $error("next mailbox wrong");
endmodule // ctms_monitor
bind ctms_top ctms_monitor u_mon (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .eng_start_i(eng_start_i),
  .eng_evt_i(eng_evt_i), .eng_pending_o(eng_pending_o), .eng_next_o(eng_next_o),
  .eng_abort_o(eng_abort_o), .irq_o(irq_o));
`default_nettype wire

// ---- verification/ctms_engine_model.sv ----
// Behavioural protocol engine and bus partner that sends queued mailboxes
`timescale 1ns/10ps
`default_nettype none
module ctms_engine_model (
  // Clock and reset
  input  wire logic                          clk_i,
  input  wire logic                          rst_i,
  // Commanded behaviour
  input  wire logic                          en_i,
  input  wire ctms_pkg::ctms_result_t        res_i,
  input  wire logic [3:0]                    wait_i,
  // Block side
  input  wire logic [ctms_pkg::NUM_MBOX-1:0] pending_i,
  input  wire logic [ctms_pkg::MBOX_W-1:0]   next_i,
  output var ctms_pkg::ctms_eng_start_t      start_o,
  output var ctms_pkg::ctms_eng_evt_t        evt_o
);
  import ctms_pkg::*;
  logic              busy;
  logic [MBOX_W-1:0] cur;
  logic [3:0]        cnt;
  // One frame at a time; the gap after an outcome lets a retry show as queued
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      busy    <= 1'b0;
      cur     <= '0;
      cnt     <= '0;
      start_o <= '0;
      evt_o   <= '0;
    end else begin
      start_o <= '0;
      evt_o   <= '0;
      if (!busy && en_i && pending_i[next_i] && !evt_o.valid) begin
        start_o <= ctms_eng_start_t'({1'b1, next_i});
        cur     <= next_i;
        cnt     <= wait_i;
        busy    <= 1'b1;
      end else if (busy && cnt == 4'h0) begin
        evt_o <= ctms_eng_evt_t'({1'b1, cur, res_i});
        busy  <= 1'b0;
      end else if (busy) begin
        cnt <= cnt - 4'h1;
      end
    end
  end
endmodule // ctms_engine_model
`default_nettype wire

// ---- verification/tb_can_tx_mailbox_status.sv ----
// Self-checking bench for the transmit mailbox status block
`timescale 1ns/10ps
`default_nettype none
module tb_can_tx_mailbox_status;
  import ctms_pkg::*;
  logic                      clk_i, rst_i, wr, rd, en, irq;
  logic [ADDR_W-1:0]         addr;
  logic [DATA_W-1:0]         wdata, rdata;
  logic [3:0]                wt;
  logic [NUM_MBOX-1:0]       pend, abrt;
  logic [MBOX_W-1:0]         nxt;
  logic [NUM_MBOX-1:0][28:0] key;
  ctms_result_t              res;
  ctms_eng_start_t           start;
  ctms_eng_evt_t             evt;
  int                        err_count, n_compared;
  ctms_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
    .rd_i(rd), .rdata_o(rdata), .key_i(key), .eng_start_i(start), .eng_evt_i(evt),
    .eng_pending_o(pend), .eng_next_o(nxt), .eng_abort_o(abrt), .irq_o(irq));
  ctms_engine_model eng_u (.clk_i(clk_i), .rst_i(rst_i), .en_i(en), .res_i(res), .wait_i(wt),
    .pending_i(pend), .next_i(nxt), .start_o(start), .evt_o(evt));
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic put(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk_i);
    wr <= 1'b0;
  endtask
  task automatic get(input string nm, input logic [7:0] a, input logic [31:0] e,
                     input logic [31:0] m = 32'hFFFF_FFFF);
    @(posedge clk_i);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk_i);
    rd <= 1'b0;
    @(negedge clk_i);
    chk(nm, e, rdata & m);
  endtask
  task automatic set_eng(input logic e, input ctms_result_t r);
    @(posedge clk_i);
    en  <= e;
    res <= r;
  endtask
  // Engine is parked at the outcome edge so a retry stays queued
  task automatic wait_evt();
    int n;
    n = 0;
    @(posedge clk_i);
    while (evt.valid !== 1'b1 && n < 64) begin
      @(posedge clk_i);
      n++;
    end
    en <= 1'b0;
    if (n == 64) chk("engine outcome", 32'h1, 32'h0);
  endtask
  task automatic t_reset();
    get("status reset", OFS_STATUS, 32'h1C00_0000);
    get("unmapped", 8'hF0, 32'h0);
    put(OFS_STATUS, 32'hFF00_0070);
    get("read-only write", OFS_STATUS, 32'h1C00_0000);
    $display("test reset done");
  endtask
  task automatic t_send();
    set_eng(1'b0, CTMS_RES_OK);
    put(OFS_TX_REQ, 32'h1);
    get("queued", OFS_STATUS, 32'h1800_0000);
    get("pending mask", OFS_TX_REQ, 32'h1);
    set_eng(1'b1, CTMS_RES_OK);
    wait_evt();
    get("sent", OFS_STATUS, 32'h1C00_0003);
    put(OFS_STATUS, 32'h0);
    get("zero write", OFS_STATUS, 32'h1C00_0003);
    put(OFS_STATUS, 32'h3);
    get("cleared", OFS_STATUS, 32'h1C00_0000);
    $display("test send done");
  endtask
  task automatic t_abort();
    put(OFS_STATUS, 32'h8000);
    get("abort vacant", OFS_STATUS, 32'h1C00_0000);
    put(OFS_TX_REQ, 32'h2);
    put(OFS_STATUS, 32'h8000);
    get("abort queued", OFS_STATUS, 32'h1C00_0100);
    put(OFS_STATUS, 32'h100);
    set_eng(1'b1, CTMS_RES_ERR);
    put(OFS_TX_REQ, 32'h2);
    while (start.valid !== 1'b1) @(posedge clk_i);
    put(OFS_STATUS, 32'h8000);
    wait_evt();
    get("abort active", OFS_STATUS, 32'h1C00_0900);
    put(OFS_STATUS, 32'h900);
    $display("test abort done");
  endtask
  task automatic t_retry();
    set_eng(1'b1, CTMS_RES_ARB);
    put(OFS_TX_REQ, 32'h4);
    wait_evt();
    get("arb lost", OFS_STATUS, 32'h0E04_0000);
    set_eng(1'b1, CTMS_RES_ERR);
    wait_evt();
    get("error retry", OFS_STATUS, 32'h0E0C_0000);
    put(OFS_CTRL, 32'h1);
    set_eng(1'b1, CTMS_RES_ERR);
    wait_evt();
    get("error final", OFS_STATUS, 32'h1C0D_0000);
    put(OFS_CTRL, 32'h0);
    put(OFS_STATUS, 32'h000F_0000);
    $display("test retry done");
  endtask
  task automatic t_prio();
    put(OFS_TX_REQ, 32'h7);
    get("three queued", OFS_STATUS, 32'h2000_0000, 32'hFCFF_FFFF);
    put(OFS_STATUS, 32'h80);
    get("two queued", OFS_STATUS, 32'h8500_0001);
    put(OFS_STATUS, 32'h0080_0000);
    get("one queued", OFS_STATUS, 32'h1501_0001);
    set_eng(1'b1, CTMS_RES_OK);
    wait_evt();
    get("drained", OFS_STATUS, 32'h1C01_0301);
    put(OFS_STATUS, 32'h0001_0301);
    put(OFS_CTRL, 32'h2);
    put(OFS_TX_REQ, 32'h1);
    put(OFS_TX_REQ, 32'h4);
    get("request order", OFS_STATUS, 32'h8800_0000);
    put(OFS_STATUS, 32'h0080_0080);
    $display("test priority done");
  endtask
  task automatic t_irq();
    get("irq flush", OFS_IRQ_STAT, 32'h1A7);
    put(OFS_IRQ_MASK, 32'h1);
    set_eng(1'b1, CTMS_RES_OK);
    put(OFS_TX_REQ, 32'h1);
    wait_evt();
    @(negedge clk_i);
    chk("irq raised", 32'h1, {31'h0, irq});
    get("irq status", OFS_IRQ_STAT, 32'h1);
    chk("irq cleared", 32'h0, {31'h0, irq});
    put(OFS_IRQ_MASK, 32'h0);
    set_eng(1'b1, CTMS_RES_OK);
    put(OFS_TX_REQ, 32'h1);
    wait_evt();
    @(negedge clk_i);
    chk("irq masked", 32'h0, {31'h0, irq});
    get("masked status", OFS_IRQ_STAT, 32'h1);
    $display("test interrupt done");
  endtask
  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Whole sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk_i);
    err_count++;
    wrap_up();
  end

  initial begin
    err_count  = 0;
    n_compared = 0;
    rst_i = 1'b1;
    addr  = '0;
    wdata = '0;
    wr    = 1'b0;
    rd    = 1'b0;
    en    = 1'b0;
    res   = CTMS_RES_OK;
    wt    = 4'h6;
    key   = {29'h2, 29'h1, 29'h3};
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_send();
    t_abort();
    t_retry();
    t_prio();
    t_irq();
    wrap_up();
  end
endmodule // tb_can_tx_mailbox_status
`default_nettype wire
